//--- design/crsc_pkg.sv
// Constants for the converter run/stop control block
package crsc_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned STOP_FILT_MS  = 16;
  localparam int unsigned STOP_RESP_MS  = 2;
  localparam int unsigned RUN_FILT_MS   = 60;
  localparam int unsigned RUN_RESP_MS   = 10;
  localparam int unsigned CLR_FILT_MS   = 60;
  localparam int unsigned CLR_RESP_MS   = 10;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned STOP_FILT_CYC = STOP_FILT_MS * CYC_PER_MS;
  localparam int unsigned STOP_RESP_CYC = STOP_RESP_MS * CYC_PER_MS;
  localparam int unsigned RUN_FILT_CYC  = RUN_FILT_MS * CYC_PER_MS;
  localparam int unsigned RUN_RESP_CYC  = RUN_RESP_MS * CYC_PER_MS;
  localparam int unsigned CLR_FILT_CYC  = CLR_FILT_MS * CYC_PER_MS;
  localparam int unsigned CLR_RESP_CYC  = CLR_RESP_MS * CYC_PER_MS;
  localparam int unsigned CNT_W         = 24;
  localparam logic        PIN_IDLE      = 1'b1;
endpackage

//--- design/crsc_filter.sv
// Stable-level input filter with edge pulses
`timescale 1ns/1ps
module crsc_filter #(
  parameter int unsigned FILT_CYC = 16,
  parameter int unsigned CNT_W    = 24
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Synchronised input
  input  wire logic i_level,
  // Filtered level and edges
  output logic      o_level,
  output logic      o_fall,
  output logic      o_rise
);
  typedef struct packed {
    logic             lvl;
    logic             fall;
    logic             rise;
    logic [CNT_W-1:0] cnt;
  } crsc_filt_s;

  crsc_filt_s st_reg;
  crsc_filt_s st_next;

  initial begin
    if (FILT_CYC < 1 || FILT_CYC >= (64'd1 << CNT_W)) begin
      $error("crsc_filter: FILT_CYC out of range");
    end
  end

  always_comb begin
    st_next      = st_reg;
    st_next.fall = 1'b0;
    st_next.rise = 1'b0;
    if (i_level == st_reg.lvl) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt == CNT_W'(FILT_CYC - 1)) begin
      st_next.cnt  = '0;
      st_next.lvl  = i_level;
      st_next.fall = ~i_level;
      st_next.rise = i_level;
    end else begin
      st_next.cnt = st_reg.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '{lvl: 1'b1, fall: 1'b0, rise: 1'b0, cnt: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_level = st_reg.lvl;
  assign o_fall  = st_reg.fall;
  assign o_rise  = st_reg.rise;

  AST_FILT_STABLE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_fall || o_rise) |-> $past(i_level, 1) == o_level)
    else $error("Filter took an edge without a stable level");
endmodule

//--- design/crsc_top.sv
// Converter run/stop control top
`timescale 1ns/1ps
module crsc_top #(
  parameter int unsigned STOP_FILT_CYC = crsc_pkg::STOP_FILT_CYC,
  parameter int unsigned STOP_RESP_CYC = crsc_pkg::STOP_RESP_CYC,
  parameter int unsigned RUN_FILT_CYC  = crsc_pkg::RUN_FILT_CYC,
  parameter int unsigned RUN_RESP_CYC  = crsc_pkg::RUN_RESP_CYC,
  parameter int unsigned CLR_FILT_CYC  = crsc_pkg::CLR_FILT_CYC,
  parameter int unsigned CLR_RESP_CYC  = crsc_pkg::CLR_RESP_CYC
) (
  // Clock and reset
  input  wire logic I_REF_CLK,
  input  wire logic I_NRST,
  // Contact inputs, low when shorted to signal ground
  input  wire logic I_STOP_N,
  input  wire logic I_RUN_N,
  input  wire logic I_ALARM_CLEAR_INPUT_N,
  // Converter control
  output logic      O_CONV_RUN,
  output logic      O_BATTERY_SELF_CV_MODE,
  output logic      O_STOP_LATCHED,
  // Open-drain alarm indication, enable high while pulling low
  output logic      O_ALARM_INDICATION_O,
  output logic      O_ALARM_INDICATION_OE
);
  localparam int unsigned W = crsc_pkg::CNT_W;

  typedef enum logic [1:0] {IDLE, RUN_WAIT, STOP_WAIT} crsc_act_e;

  typedef struct packed {
    logic [2:0]   pin_s1;
    logic [2:0]   pin_s2;
    logic         run;
    logic         latched;
    logic         alarm;
    logic         stop_pend;
    logic [W-1:0] stop_cnt;
    crsc_act_e    act;
    logic [W-1:0] run_cnt;
    logic         clr_pend;
    logic [W-1:0] clr_cnt;
  } crsc_top_s;

  crsc_top_s st_reg;
  crsc_top_s st_next;
  // Kept out of the struct: it is reset by the pin, not by its own output
  logic [1:0] rst_sync_reg;
  logic      rst_n;
  logic      stop_fall;
  logic      run_lvl;
  logic      run_fall;
  logic      run_rise;
  logic      clr_rise;

  initial begin
    if (STOP_RESP_CYC < 1 || RUN_RESP_CYC < 1 || CLR_RESP_CYC < 1) begin
      $error("crsc_top: response counts must be at least one");
    end
    if (STOP_RESP_CYC >= (64'd1 << W) || RUN_RESP_CYC >= (64'd1 << W)
        || CLR_RESP_CYC >= (64'd1 << W)) begin
      $error("crsc_top: response counts too wide for the counters");
    end
  end

  // Reset release through two flops
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  crsc_filter #(.FILT_CYC(STOP_FILT_CYC), .CNT_W(W)) u_stop_filt (
    .i_clk   (I_REF_CLK),
    .i_rst_n (rst_n),
    .i_level (st_reg.pin_s2[0]),
    .o_level (),
    .o_fall  (stop_fall),
    .o_rise  ()
  );

  crsc_filter #(.FILT_CYC(RUN_FILT_CYC), .CNT_W(W)) u_run_filt (
    .i_clk   (I_REF_CLK),
    .i_rst_n (rst_n),
    .i_level (st_reg.pin_s2[1]),
    .o_level (run_lvl),
    .o_fall  (run_fall),
    .o_rise  (run_rise)
  );

  crsc_filter #(.FILT_CYC(CLR_FILT_CYC), .CNT_W(W)) u_clr_filt (
    .i_clk   (I_REF_CLK),
    .i_rst_n (rst_n),
    .i_level (st_reg.pin_s2[2]),
    .o_level (),
    .o_fall  (),
    .o_rise  (clr_rise)
  );

  always_comb begin
    st_next          = st_reg;
    st_next.pin_s1   = {I_ALARM_CLEAR_INPUT_N, I_RUN_N, I_STOP_N};
    st_next.pin_s2   = st_reg.pin_s1;
    // Forced stop: filtered edge, then response delay
    if (stop_fall) begin
      st_next.stop_pend = 1'b1;
      st_next.stop_cnt  = '0;
    end else if (st_reg.stop_pend) begin
      if (st_reg.stop_cnt == W'(STOP_RESP_CYC - 1)) begin
        st_next.stop_pend = 1'b0;
        st_next.latched   = 1'b1;
        st_next.alarm     = 1'b1;
        st_next.run       = 1'b0;
        st_next.act       = IDLE;
      end else begin
        st_next.stop_cnt = st_reg.stop_cnt + W'(1);
      end
    end
    // Alarm clear on release edge, after response delay
    if (clr_rise) begin
      st_next.clr_pend = 1'b1;
      st_next.clr_cnt  = '0;
    end else if (st_reg.clr_pend) begin
      if (st_reg.clr_cnt == W'(CLR_RESP_CYC - 1)) begin
        st_next.clr_pend = 1'b0;
        // A stop landing now wins over the clear
        if (!(st_reg.stop_pend && st_reg.stop_cnt == W'(STOP_RESP_CYC - 1))) begin
          st_next.latched = 1'b0;
          st_next.alarm   = 1'b0;
          // Resume only if run contact still closed
          st_next.run     = ~run_lvl;
          st_next.act     = IDLE;
        end
      end else begin
        st_next.clr_cnt = st_reg.clr_cnt + W'(1);
      end
    end
    // Run contact handling, ignored while latched
    if (!st_reg.latched && !st_next.latched) begin
      case (st_reg.act)
        IDLE: begin
          if (run_fall) begin
            st_next.act     = RUN_WAIT;
            st_next.run_cnt = '0;
          end else if (run_rise) begin
            st_next.act     = STOP_WAIT;
            st_next.run_cnt = '0;
          end
        end
        RUN_WAIT, STOP_WAIT: begin
          if (run_fall || run_rise) begin
            st_next.act     = run_fall ? RUN_WAIT : STOP_WAIT;
            st_next.run_cnt = '0;
          end else if (st_reg.run_cnt == W'(RUN_RESP_CYC - 1)) begin
            st_next.run = (st_reg.act == RUN_WAIT);
            st_next.act = IDLE;
          end else begin
            st_next.run_cnt = st_reg.run_cnt + W'(1);
          end
        end
        default: begin
          st_next.act = IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.pin_s1    <= 3'h7;
      st_reg.pin_s2    <= 3'h7;
      st_reg.run       <= 1'b0;
      st_reg.latched   <= 1'b0;
      st_reg.alarm     <= 1'b0;
      st_reg.stop_pend <= 1'b0;
      st_reg.stop_cnt  <= '0;
      st_reg.act       <= IDLE;
      st_reg.run_cnt   <= '0;
      st_reg.clr_pend  <= 1'b0;
      st_reg.clr_cnt   <= '0;
    end else begin
      st_reg.pin_s1    <= st_next.pin_s1;
      st_reg.pin_s2    <= st_next.pin_s2;
      st_reg.run       <= st_next.run;
      st_reg.latched   <= st_next.latched;
      st_reg.alarm     <= st_next.alarm;
      st_reg.stop_pend <= st_next.stop_pend;
      st_reg.stop_cnt  <= st_next.stop_cnt;
      st_reg.act       <= st_next.act;
      st_reg.run_cnt   <= st_next.run_cnt;
      st_reg.clr_pend  <= st_next.clr_pend;
      st_reg.clr_cnt   <= st_next.clr_cnt;
    end
  end

  assign O_CONV_RUN             = st_reg.run;
  assign O_BATTERY_SELF_CV_MODE = st_reg.run;
  assign O_STOP_LATCHED         = st_reg.latched;
  // Conducting normally, released open on alarm
  assign O_ALARM_INDICATION_O   = 1'b0;
  assign O_ALARM_INDICATION_OE  = ~st_reg.alarm;

  AST_STOP_LATCH: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
    (st_reg.stop_pend && st_reg.stop_cnt == W'(STOP_RESP_CYC - 1)) |=> O_STOP_LATCHED)
    else $error("Forced stop did not latch");
  AST_STOP_NORUN: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
    O_STOP_LATCHED |-> !O_CONV_RUN)
    else $error("Converter running while stop latched");
  AST_HOLD: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
    ($fell(O_STOP_LATCHED)) |-> $past(st_reg.clr_pend))
    else $error("Latch released without alarm clear");
  AST_ALARM_SET: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
    $rose(O_STOP_LATCHED) |-> !O_ALARM_INDICATION_OE)
    else $error("Alarm not raised with forced stop");
  AST_RUN_ON: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
    $rose(O_CONV_RUN) |-> (!$past(run_lvl) && !O_STOP_LATCHED))
    else $error("Run started without closed contact");
  AST_RUN_OFF: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
    (st_reg.act == STOP_WAIT && !run_fall && !run_rise && !st_reg.latched
     && !st_reg.stop_pend && !st_reg.clr_pend
     && st_reg.run_cnt == W'(RUN_RESP_CYC - 1)) |=> !O_CONV_RUN)
    else $error("Run release did not stop converter");
  AST_MODE: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
    O_CONV_RUN |-> O_BATTERY_SELF_CV_MODE)
    else $error("Running outside battery self CV mode");
  AST_ALARM_PIN: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
    O_STOP_LATCHED |-> !O_ALARM_INDICATION_OE)
    else $error("Alarm pin conducting during latched stop");
  AST_RUN_COUNT: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
    (st_reg.act != IDLE) |-> st_reg.run_cnt < W'(RUN_RESP_CYC))
    else $error("Run response counter overran");
endmodule

//--- test/crsc_contact.sv
// Dry contact model with optional bounce on each change
`timescale 1ns/1ps
module crsc_contact (
  // Clock
  input  wire logic       i_clk,
  // Contact closed requests and bounce enable
  input  wire logic [2:0] i_close,
  input  wire logic       i_bounce,
  // Pins, pulled up when open
  output logic      [2:0] o_pin_n
);
  logic [2:0] closed_reg = 3'h0;
  int         bnc_reg[3] = '{0, 0, 0};

  // Bounce toggles the pin for four cycles, so filters must restart
  always @(posedge i_clk) begin
    for (int k = 0; k < 3; k++) begin
      if (i_close[k] !== closed_reg[k]) begin
        closed_reg[k] <= i_close[k];
        bnc_reg[k]    <= i_bounce ? 4 : 0;
      end else if (bnc_reg[k] > 0) begin
        bnc_reg[k] <= bnc_reg[k] - 1;
      end
    end
  end

  always_comb begin
    for (int k = 0; k < 3; k++) begin
      o_pin_n[k] = ~closed_reg[k] ^ ((bnc_reg[k] % 2) == 1);
    end
  end
endmodule

//--- test/tb_crsc_top.sv
// Self-checking bench for the run/stop control block
`timescale 1ns/1ps
module tb_crsc_top;
  localparam int SF = 8;
  localparam int SR = 4;
  localparam int RF = 12;
  localparam int RR = 6;
  localparam int CF = 10;
  localparam int CR = 5;
  logic       I_REF_CLK = 1'b0;
  logic       I_NRST = 1'b0;
  logic [2:0] close = 3'h0;
  logic       bounce = 1'b0;
  logic [2:0] pin_n;
  logic       O_CONV_RUN;
  logic       O_BATTERY_SELF_CV_MODE;
  logic       O_STOP_LATCHED;
  logic       O_ALARM_INDICATION_O;
  logic       O_ALARM_INDICATION_OE;
  int         errors = 0;
  int         compares = 0;
  int         cycles = 0;

  crsc_contact partner (.i_clk(I_REF_CLK), .i_close(close), .i_bounce(bounce), .o_pin_n(pin_n));
  crsc_top #(.STOP_FILT_CYC(SF), .STOP_RESP_CYC(SR), .RUN_FILT_CYC(RF),
    .RUN_RESP_CYC(RR), .CLR_FILT_CYC(CF), .CLR_RESP_CYC(CR)) uut (
    .I_REF_CLK(I_REF_CLK), .I_NRST(I_NRST), .I_STOP_N(pin_n[0]), .I_RUN_N(pin_n[1]),
    .I_ALARM_CLEAR_INPUT_N(pin_n[2]), .O_CONV_RUN(O_CONV_RUN),
    .O_BATTERY_SELF_CV_MODE(O_BATTERY_SELF_CV_MODE), .O_STOP_LATCHED(O_STOP_LATCHED),
    .O_ALARM_INDICATION_O(O_ALARM_INDICATION_O), .O_ALARM_INDICATION_OE(O_ALARM_INDICATION_OE));

  initial begin
    forever #5 I_REF_CLK = ~I_REF_CLK;
  end

  // Whole run needs well under 2000 cycles
  always @(posedge I_REF_CLK) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %b seen %b", nm, exp, got);
    end
  endtask

  function automatic logic get(input int sel);
    case (sel)
      0:       return O_CONV_RUN;
      1:       return O_STOP_LATCHED;
      default: return O_ALARM_INDICATION_OE;
    endcase
  endfunction

  // Counts cycles until an output reaches a level; early or late is a mismatch
  task automatic lat(input int sel, input logic val, input int lo, input int hi, input string nm);
    int n;
    n = 0;
    while (get(sel) !== val && n <= hi) begin
      @(posedge I_REF_CLK);
      #1;
      n++;
    end
    compares++;
    if (n < lo || n > hi) begin
      errors++;
      $display("BAD %s latency expected %0d..%0d seen %0d", nm, lo, hi, n);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge I_REF_CLK);
    #1;
  endtask

  task automatic set_c(input int k, input logic v);
    @(posedge I_REF_CLK);
    close[k] <= v;
    #1;
  endtask

  task automatic t_reset();
    chk("run", 1'b0, O_CONV_RUN);
    chk("latched", 1'b0, O_STOP_LATCHED);
    chk("alarm_oe", 1'b1, O_ALARM_INDICATION_OE);
    chk("alarm_o", 1'b0, O_ALARM_INDICATION_O);
  endtask

  task automatic t_run();
    bounce <= 1'b1;
    set_c(1, 1'b1);
    lat(0, 1'b1, RF + RR + 4, RF + RR + 16, "run_start");
    chk("cv_mode", 1'b1, O_BATTERY_SELF_CV_MODE);
    cyc(40);
    chk("run_held", 1'b1, O_CONV_RUN);
    bounce <= 1'b0;
    set_c(1, 1'b0);
    lat(0, 1'b0, RF + RR, RF + RR + 10, "run_stop");
    chk("cv_mode_off", 1'b0, O_BATTERY_SELF_CV_MODE);
  endtask

  task automatic t_glitch();
    set_c(1, 1'b1);
    cyc(RF - 4);
    set_c(1, 1'b0);
    cyc(40);
    chk("run_glitch", 1'b0, O_CONV_RUN);
  endtask

  task automatic force_stop();
    set_c(0, 1'b1);
    lat(1, 1'b1, SF + SR, SF + SR + 10, "stop_latch");
    chk("run_stopped", 1'b0, O_CONV_RUN);
    chk("alarm_oe", 1'b0, O_ALARM_INDICATION_OE);
    chk("alarm_o", 1'b0, O_ALARM_INDICATION_O);
    set_c(0, 1'b0);
    cyc(40);
    chk("latch_held", 1'b1, O_STOP_LATCHED);
  endtask

  task automatic clear_alarm(input logic run_exp);
    set_c(2, 1'b1);
    cyc(CF + 10);
    chk("latch_until_release", 1'b1, O_STOP_LATCHED);
    set_c(2, 1'b0);
    lat(1, 1'b0, CF + CR, CF + CR + 10, "clear");
    chk("alarm_oe", 1'b1, O_ALARM_INDICATION_OE);
    cyc(3);
    chk("run_resume", run_exp, O_CONV_RUN);
  endtask

  task automatic t_stop_clear();
    set_c(1, 1'b1);
    lat(0, 1'b1, RF + RR, RF + RR + 10, "run_start");
    force_stop();
    set_c(1, 1'b0);
    cyc(40);
    set_c(1, 1'b1);
    cyc(40);
    chk("run_locked", 1'b0, O_CONV_RUN);
    clear_alarm(1'b1);
    force_stop();
    set_c(1, 1'b0);
    cyc(40);
    clear_alarm(1'b0);
  endtask

  initial begin
    cyc(6);
    t_reset();
    @(posedge I_REF_CLK);
    I_NRST <= 1'b1;
    cyc(6);
    t_reset();
    t_run();
    t_glitch();
    t_stop_clear();
    end_of_test();
  end
endmodule
